// ---- design/bghs_consts.svh ----
// Offsets, field positions, reset values and timing counts of the bridge GPIO block.
`ifndef BGHS_CONSTS_SVH
`define BGHS_CONSTS_SVH
// ****************************************************************
// Register map and fields
// ****************************************************************
`define BGHS_REG_XGPIO 16'h0304
`define BGHS_REG_XGPIO_HI 16'h0306
`define BGHS_XGPIO_RST 32'h0000_0000
`define BGHS_F_GPO_CLR 3:0
`define BGHS_F_GPO_SET 7:4
`define BGHS_F_EN_CLR 11:8
`define BGHS_F_EN_SET 15:12
// ****************************************************************
// Management bus
// ****************************************************************
`define BGHS_SMB_CMD 8'h08
`define BGHS_SMB_ADDR_FIXED 3'h6
// ****************************************************************
// Timing
// ****************************************************************
`define BGHS_CLK_HZ 40000000
`define BGHS_DB_MS 5
`define BGHS_DB_CYC ((`BGHS_CLK_HZ / 1000) * `BGHS_DB_MS)
`define BGHS_BLINK_HZ 2
`define BGHS_BLINK_CYC (`BGHS_CLK_HZ / (2 * `BGHS_BLINK_HZ))
`endif

// ---- design/bghs_pkg.sv ----
// Types shared by the bridge GPIO, hot-plug and management bus block.
package bghs_pkg;
  typedef enum logic [2:0] {
    SM_IDLE = 3'b000,
    SM_RX = 3'b001,
    SM_ACK = 3'b010,
    SM_TX = 3'b011,
    SM_RACK = 3'b100
  } bghs_sm_t;

  typedef enum logic [1:0] {
    IND_RSVD = 2'b00,
    IND_ON = 2'b01,
    IND_BLINK = 2'b10,
    IND_OFF = 2'b11
  } bghs_ind_t;

  typedef struct packed {
    logic [3:0] gpo;
    logic [3:0] gpo_en;
    logic [3:0] gpi;
    logic [3:0] xgpo;
    logic [3:0] xgpo_oe;
    logic [2:0] gnt_n;
    logic [2:0] gnt_oe;
    logic [31:0] cfg_rdata;
    logic cfg_ack;
    logic strap_done;
    logic [6:0] smb_addr;
    logic [23:0] db_cnt;
    logic btn_stable;
    logic btn_msg;
    logic [23:0] bl_cnt;
    logic blink;
    bghs_ind_t attn;
    bghs_ind_t pwr;
    logic ind_o;
    logic ind_oe;
    logic ind_msg_v;
    bghs_ind_t msg_attn;
    bghs_ind_t msg_pwr;
    logic [4:0] sts;
    logic latch_q;
    logic pres_q;
    logic dll_q;
    logic hp_evt;
    bghs_sm_t sm;
    logic scl_q;
    logic sda_q;
    logic [7:0] sh;
    logic [3:0] bitc;
    logic [2:0] idx;
    logic rd;
    logic ack;
    logic armed;
    logic [1:0] phase;
    logic [7:0] b_lo;
    logic [7:0] b_hi;
    logic [15:0] reg_num;
    logic [15:0] rdat;
    logic sda_oe;
    logic sda_o;
  } bghs_state_t;
endpackage : bghs_pkg

// ---- design/bghs_gpio.sv ----
// Extra GPIO register, hot-plug pin functions and management bus slave of the bridge.
//
// Function
// - Ones written to bits 3:0 clear output data bits; reset zero.
// - Ones written to bits 7:4 set output data bits 3:0.
// - Ones written to bits 11:8 clear output enable bits; reset zero.
// - Ones written to bits 15:12 set output enable bits.
// - Bits 19:16 read sampled input pins; bits 31:20 read zero.
// - Hot-plug strap high gives the four GPIO pins hot-plug functions.
// - Forward: GPIO0 presence, GPIO1 button, GPIO2 latch closed.
// - Forward: GPIO3 high attention, low power, undriven when both off.
// - Forward: debounced button press sends a button message upstream.
// - Forward: indicator messages set GPIO3 on, off or 2Hz blink.
// - Reverse: button message or input sets status, event if enabled.
// - Reverse: control write sends indicator message and updates indicator.
// - Reverse: latch change updates status and raises enabled event.
// - Reverse: presence change updates status and raises enabled event.
// - Reverse: command completion sets its bit and raises enabled event.
// - Reverse: link active change updates status and raises enabled event.
// - Management strap high makes GPIO pins slave address straps.
// - Slave address is 110 followed by GPIO3 down to GPIO0.
// - Word write: three writes with command 08h: bus/devfn, register, data.
// - Word read: bus/devfn, register, command, restart, low then high byte.
// - External arbiter reuses request inputs and grant outputs as extra GPIO.
// - Management bus needs straps high zero, low one; the EEPROM mode output is always zero.
`timescale 1ns/10ps
`default_nettype none
`include "bghs_consts.svh"

module bghs_gpio
  import bghs_pkg::*;
#(
  parameter logic [23:0] DB_CYC = 24'(`BGHS_DB_CYC),
  parameter logic [23:0] BLINK_CYC = 24'(`BGHS_BLINK_CYC)
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Straps and modes.
  input wire logic hotplug_strap_i,
  input wire logic mgmt_bus_strap_lo_i,
  input wire logic mgmt_bus_strap_hi_i,
  input wire logic fwd_mode_i,
  input wire logic ext_arb_i,
  output logic eeprom_mode_o,
  // Configuration access from the link side.
  input wire logic cfg_req_i,
  input wire logic cfg_we_i,
  input wire logic [15:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  // Extra general pins and arbiter pins.
  input wire logic [3:0] xgpi_i,
  output logic [3:0] xgpo_o,
  output logic [3:0] xgpo_oe_o,
  input wire logic [2:0] req_n_i,
  input wire logic [2:0] arb_gnt_n_i,
  output logic [2:0] gnt_n_o,
  output logic [2:0] gnt_oe_o,
  // Hot-plug GPIO pins; only GPIO3 is ever driven.
  input wire logic [3:0] gpio_i,
  output logic gpio3_o,
  output logic gpio3_oe_o,
  // Hot-plug messages and slot status.
  input wire logic ind_msg_in_valid_i,
  input wire logic ind_msg_in_attn_i,
  input wire logic [1:0] ind_msg_in_state_i,
  output logic btn_msg_o,
  output logic ind_msg_valid_o,
  output logic [1:0] ind_msg_attn_o,
  output logic [1:0] ind_msg_pwr_o,
  input wire logic btn_msg_i,
  input wire logic slot_ctl_wr_i,
  input wire logic [1:0] slot_attn_ctl_i,
  input wire logic [1:0] slot_pwr_ctl_i,
  input wire logic cmd_done_i,
  input wire logic dll_active_i,
  input wire logic hp_en_i,
  input wire logic [4:0] slot_sts_clr_i,
  output logic [7:0] slot_sts_o,
  output logic hp_event_o,
  // Management bus pins.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Applies a write word to {enable, data}; a set beats a clear in the same write.
  function automatic logic [7:0] bghs_apply(input logic [7:0] cur, input logic [15:0] w);
    logic [3:0] d;
    logic [3:0] e;
    d = (cur[3:0] & ~w[`BGHS_F_GPO_CLR]) | w[`BGHS_F_GPO_SET];
    e = (cur[7:4] & ~w[`BGHS_F_EN_CLR]) | w[`BGHS_F_EN_SET];
    return {e, d};
  endfunction : bghs_apply

  // Read value; set and clear fields both show the current bit.
  function automatic logic [31:0] bghs_rd(input logic [3:0] gpi, input logic [3:0] en, input logic [3:0] d);
    return {12'h000, gpi, en, en, d, d};
  endfunction : bghs_rd

  // Indicator lamp level for a state and the blink phase.
  function automatic logic bghs_lit(input bghs_ind_t s, input logic ph);
    return (s == IND_ON) || ((s == IND_BLINK) && ph);
  endfunction : bghs_lit

  bghs_state_t q;
  bghs_state_t n;
  logic [31:0] rd_word;
  logic smb_en;
  logic hp_fwd;
  logic hp_rev;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic press;
  logic [4:0] ev;
  logic [7:0] upd;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Decodes shared by the processes below.
  assign rd_word = bghs_rd(q.gpi, q.gpo_en, q.gpo);
  assign smb_en = mgmt_bus_strap_lo_i && !mgmt_bus_strap_hi_i;
  assign hp_fwd = hotplug_strap_i && fwd_mode_i;
  assign hp_rev = hotplug_strap_i && !fwd_mode_i;
  assign rise = scl_i && !q.scl_q;
  assign fall = !scl_i && q.scl_q;
  assign start = scl_i && q.scl_q && q.sda_q && !sda_i;
  assign stop = scl_i && q.scl_q && !q.sda_q && sda_i;

  // One process computes every next value; reset is folded in because it is synchronous.
  always_comb begin
    n = q;
    press = 1'b0;
    ev = 5'h00;
    upd = {q.gpo_en, q.gpo};
    n.btn_msg = 1'b0;
    n.hp_evt = 1'b0;
    n.ind_msg_v = 1'b0;
    n.cfg_ack = 1'b0;
    n.sda_o = 1'b0;
    n.scl_q = scl_i;
    n.sda_q = sda_i;
    // Extra inputs; with an external arbiter the spare request pins feed GPI 2:0.
    n.gpi = ext_arb_i ? {xgpi_i[3], req_n_i} : xgpi_i;
    // Address straps are taken once, in the first cycle after reset release.
    if (!q.strap_done) begin
      n.strap_done = 1'b1;
      n.smb_addr = {`BGHS_SMB_ADDR_FIXED, gpio_i};
    end
    // Button debounce: a new level must hold for the whole window before it counts.
    if (gpio_i[1] == q.btn_stable) begin
      n.db_cnt = 24'h000000;
    end else if (q.db_cnt >= DB_CYC - 24'h000001) begin
      n.db_cnt = 24'h000000;
      n.btn_stable = gpio_i[1];
      press = gpio_i[1] && hotplug_strap_i;
    end else begin
      n.db_cnt = q.db_cnt + 24'h000001;
    end
    // Blink phase toggles every half period for an even duty cycle.
    if (q.bl_cnt >= BLINK_CYC - 24'h000001) begin
      n.bl_cnt = 24'h000000;
      n.blink = !q.blink;
    end else begin
      n.bl_cnt = q.bl_cnt + 24'h000001;
    end
    n.btn_msg = press && fwd_mode_i;
    // Forward mode: indicator messages from upstream steer the lamp states.
    if (hp_fwd && ind_msg_in_valid_i) begin
      if (ind_msg_in_attn_i) begin
        n.attn = bghs_ind_t'(ind_msg_in_state_i);
      end else begin
        n.pwr = bghs_ind_t'(ind_msg_in_state_i);
      end
    end
    // Reverse mode: a control write updates the lamps and is echoed as a message.
    if (hp_rev && slot_ctl_wr_i) begin
      n.attn = bghs_ind_t'(slot_attn_ctl_i);
      n.pwr = bghs_ind_t'(slot_pwr_ctl_i);
      n.msg_attn = bghs_ind_t'(slot_attn_ctl_i);
      n.msg_pwr = bghs_ind_t'(slot_pwr_ctl_i);
      n.ind_msg_v = 1'b1;
    end
    // GPIO3 is shared: attention wins high, power drives low, otherwise released.
    n.ind_oe = 1'b0;
    n.ind_o = 1'b0;
    if (hotplug_strap_i && bghs_lit(q.attn, q.blink)) begin
      n.ind_oe = 1'b1;
      n.ind_o = 1'b1;
    end else if (hotplug_strap_i && bghs_lit(q.pwr, q.blink)) begin
      n.ind_oe = 1'b1;
    end
    // Reverse-mode slot events; a new event beats a clear in the same cycle.
    ev[0] = hp_rev && (press || btn_msg_i);
    ev[1] = hp_rev && (gpio_i[2] != q.latch_q);
    ev[2] = hp_rev && (gpio_i[0] != q.pres_q);
    ev[3] = hp_rev && cmd_done_i;
    ev[4] = hp_rev && (dll_active_i != q.dll_q);
    n.sts = (q.sts & ~slot_sts_clr_i) | ev;
    n.hp_evt = hp_en_i && (ev != 5'h00);
    n.latch_q = gpio_i[2];
    n.pres_q = gpio_i[0];
    n.dll_q = dll_active_i;
    // Management bus slave; bits are sampled on SCL rise and driven after SCL fall.
    if (!smb_en) begin
      n.sm = SM_IDLE;
      n.sda_oe = 1'b0;
    end else if (start) begin
      n.sm = SM_RX;
      n.bitc = 4'h0;
      n.idx = 3'h0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      // A complete four-byte write advances the access sequence.
      if (q.idx == 3'h4 && !q.rd) begin
        unique case (q.phase)
          2'h0: n.phase = 2'h1;
          2'h1: begin
            n.reg_num = {q.b_hi, q.b_lo};
            n.phase = 2'h2;
          end
          default: begin
            if (q.reg_num == `BGHS_REG_XGPIO) begin
              upd = bghs_apply(upd, {q.b_hi, q.b_lo});
            end
            n.phase = 2'h0;
          end
        endcase
      end
      n.sm = SM_IDLE;
      n.armed = 1'b0;
      n.sda_oe = 1'b0;
    end else begin
      unique case (q.sm)
        SM_IDLE: begin
          n.sda_oe = 1'b0;
        end
        SM_RX: begin
          if (rise && q.bitc != 4'h8) begin
            n.sh = {q.sh[6:0], sda_i};
            n.bitc = q.bitc + 4'h1;
          end else if (fall && q.bitc == 4'h8) begin
            n.ack = 1'b0;
            unique case (q.idx)
              3'h0: begin
                n.rd = q.sh[0];
                n.ack = (q.sh[7:1] == q.smb_addr) && (!q.sh[0] || q.armed);
                n.rdat = (q.reg_num == `BGHS_REG_XGPIO) ? rd_word[15:0] :
                         (q.reg_num == `BGHS_REG_XGPIO_HI) ? rd_word[31:16] : 16'h0000;
              end
              3'h1: begin
                n.ack = (q.sh == `BGHS_SMB_CMD);
                n.armed = (q.sh == `BGHS_SMB_CMD) && (q.phase == 2'h2);
              end
              3'h2: begin
                n.b_lo = q.sh;
                n.ack = 1'b1;
              end
              3'h3: begin
                n.b_hi = q.sh;
                n.ack = 1'b1;
              end
              default: n.ack = 1'b0;
            endcase
            n.sm = n.ack ? SM_ACK : SM_IDLE;
            n.sda_oe = n.ack;
            n.idx = q.idx + 3'h1;
            n.bitc = 4'h0;
          end
        end
        SM_ACK: begin
          if (fall) begin
            n.sm = q.rd ? SM_TX : SM_RX;
            n.sh = q.rdat[7:0];
            n.sda_oe = q.rd && !q.rdat[7];
          end
        end
        SM_TX: begin
          if (rise) begin
            n.bitc = q.bitc + 4'h1;
          end else if (fall && q.bitc == 4'h8) begin
            n.sda_oe = 1'b0;
            n.sm = SM_RACK;
          end else if (fall) begin
            n.sh = {q.sh[6:0], 1'b0};
            n.sda_oe = !q.sh[6];
          end
        end
        SM_RACK: begin
          if (rise) begin
            n.ack = !sda_i;
            n.idx = q.idx + 3'h1;
          end else if (fall) begin
            // The host's NACK after the high byte ends the read sequence.
            n.sm = (q.ack && q.idx == 3'h2) ? SM_TX : SM_IDLE;
            n.phase = q.ack ? q.phase : 2'h0;
            n.sh = q.rdat[15:8];
            n.sda_oe = q.ack && (q.idx == 3'h2) && !q.rdat[15];
            n.bitc = 4'h0;
          end
        end
        default: n.sm = SM_IDLE;
      endcase
    end
    // Link-side configuration access; applied after the bus write so both take effect.
    if (cfg_req_i) begin
      n.cfg_ack = 1'b1;
      n.cfg_rdata = (cfg_addr_i == `BGHS_REG_XGPIO) ? rd_word : 32'h0000_0000;
      if (cfg_we_i && cfg_addr_i == `BGHS_REG_XGPIO) begin
        upd = bghs_apply(upd, cfg_wdata_i[15:0]);
      end
    end
    n.gpo = upd[3:0];
    n.gpo_en = upd[7:4];
    // Pins follow the register one cycle later; undriven while disabled.
    n.xgpo = q.gpo;
    n.xgpo_oe = q.gpo_en;
    n.gnt_n = ext_arb_i ? q.gpo[2:0] : arb_gnt_n_i;
    n.gnt_oe = ext_arb_i ? q.gpo_en[2:0] : 3'h7;
    if (rst_i) begin
      n = '0;
      n.attn = IND_OFF;
      n.pwr = IND_OFF;
      n.msg_attn = IND_OFF;
      n.msg_pwr = IND_OFF;
      n.scl_q = 1'b1;
      n.sda_q = 1'b1;
      n.gnt_n = 3'h7;
      n.gnt_oe = 3'h7;
      n.sm = SM_IDLE;
    end
  end

  // ****************************************************************
  // State register and outputs
  // ****************************************************************

  // All state lives in one register.
  always_ff @(posedge clk_i) begin
    q <= n;
  end

  // Outputs come straight from the state register; eeprom_mode_o is tied low.
  assign eeprom_mode_o = 1'b0;
  assign cfg_rdata_o = q.cfg_rdata;
  assign cfg_ack_o = q.cfg_ack;
  assign xgpo_o = q.xgpo;
  assign xgpo_oe_o = q.xgpo_oe;
  assign gnt_n_o = q.gnt_n;
  assign gnt_oe_o = q.gnt_oe;
  assign gpio3_o = q.ind_o;
  assign gpio3_oe_o = q.ind_oe;
  assign btn_msg_o = q.btn_msg;
  assign ind_msg_valid_o = q.ind_msg_v;
  assign ind_msg_attn_o = q.msg_attn;
  assign ind_msg_pwr_o = q.msg_pwr;
  assign slot_sts_o = {q.dll_q, q.pres_q, q.latch_q, q.sts};
  assign hp_event_o = q.hp_evt;
  assign sda_o = q.sda_o;
  assign sda_oe_o = q.sda_oe;

endmodule : bghs_gpio

`default_nettype wire

// ---- tb/bghs_gpio_monitor.sv ----
// Port-level checker of the bridge GPIO block.
`timescale 1ns/10ps
`default_nettype none
module bghs_gpio_monitor (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports.
  input wire logic hotplug_strap_i,
  input wire logic mgmt_bus_strap_lo_i,
  input wire logic mgmt_bus_strap_hi_i,
  input wire logic fwd_mode_i,
  input wire logic cfg_req_i,
  input wire logic cfg_we_i,
  input wire logic [15:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic cfg_ack_o,
  input wire logic [3:0] xgpo_o,
  input wire logic [3:0] xgpo_oe_o,
  input wire logic [3:0] gpio_i,
  input wire logic dll_active_i,
  input wire logic hp_en_i,
  input wire logic slot_ctl_wr_i,
  input wire logic [1:0] slot_attn_ctl_i,
  input wire logic [7:0] slot_sts_o,
  input wire logic hp_event_o,
  input wire logic ind_msg_valid_o,
  input wire logic [1:0] ind_msg_attn_o,
  input wire logic sda_oe_o
);
  logic rev, wr;
  // Reverse hot-plug mode, and a write to the extra GPIO register.
  assign rev = hotplug_strap_i & ~fwd_mode_i;
  assign wr = cfg_req_i & cfg_we_i & (cfg_addr_i == 16'h0304);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Clears are checked only without a set, since a set wins.
  property p_clr; wr && cfg_wdata_i[7:4] == 4'h0 ##1 !cfg_req_i |=> (xgpo_o & 4'($past(cfg_wdata_i, 2))) == 4'h0; endproperty
  property p_set; wr ##1 !cfg_req_i |=> (xgpo_o & 4'($past(cfg_wdata_i, 2) >> 4)) == 4'($past(cfg_wdata_i, 2) >> 4); endproperty
  property p_eclr; wr && cfg_wdata_i[15:12] == 4'h0 ##1 !cfg_req_i |=> (xgpo_oe_o & 4'($past(cfg_wdata_i, 2) >> 8)) == 4'h0; endproperty
  property p_eset; wr ##1 !cfg_req_i |=> (xgpo_oe_o & 4'($past(cfg_wdata_i, 2) >> 12)) == 4'($past(cfg_wdata_i, 2) >> 12); endproperty
  property p_rd; cfg_req_i && !cfg_we_i |=> cfg_ack_o && cfg_rdata_o[31:20] == 12'h000; endproperty
  property p_pres; rev && hp_en_i && $changed(gpio_i[0]) |=> slot_sts_o[2] && hp_event_o && slot_sts_o[6] == $past(gpio_i[0]); endproperty
  property p_dll; rev && hp_en_i && $changed(dll_active_i) |=> slot_sts_o[4] && hp_event_o && slot_sts_o[7] == $past(dll_active_i); endproperty
  property p_ind; rev && slot_ctl_wr_i |=> ind_msg_valid_o && ind_msg_attn_o == $past(slot_attn_ctl_i); endproperty
  // The output enable is registered, so the strap must be off for two edges.
  property p_quiet; !(mgmt_bus_strap_lo_i && !mgmt_bus_strap_hi_i) [*2] |-> !sda_oe_o; endproperty
  a_clr: assert property (p_clr) else $error("output data bit not cleared");
  a_set: assert property (p_set) else $error("output data bit not set");
  a_eclr: assert property (p_eclr) else $error("output enable not cleared");
  a_eset: assert property (p_eset) else $error("output enable not set");
  a_rd: assert property (p_rd) else $error("read answer wrong");
  a_pres: assert property (p_pres) else $error("presence change not reported");
  a_dll: assert property (p_dll) else $error("link active change not reported");
  a_ind: assert property (p_ind) else $error("indicator message missing");
  a_quiet: assert property (p_quiet) else $error("data line driven while bus off");
  c_wr: cover property (wr);
  c_evt: cover property (hp_event_o);
  c_drv: cover property (sda_oe_o);
endmodule : bghs_gpio_monitor
bind bghs_gpio bghs_gpio_monitor i_bghs_gpio_monitor (.clk_i, .rst_i, .hotplug_strap_i, .mgmt_bus_strap_lo_i,
  .mgmt_bus_strap_hi_i, .fwd_mode_i, .cfg_req_i, .cfg_we_i, .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_ack_o,
  .xgpo_o, .xgpo_oe_o, .gpio_i, .dll_active_i, .hp_en_i, .slot_ctl_wr_i, .slot_attn_ctl_i, .slot_sts_o,
  .hp_event_o, .ind_msg_valid_o, .ind_msg_attn_o, .sda_oe_o);
`default_nettype wire

// ---- tb/bghs_smb_host.sv ----
// Management bus host model that clocks the slave and drives the shared data line.
`timescale 1ns/10ps
`default_nettype none
module bghs_smb_host (
  // Core clock pacing the bus.
  input wire logic clk_i,
  // Slave pull-down and bus lines.
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  logic drv = 1'b1;
  // The pull-up wins unless one party pulls low.
  assign sda_o = drv & ~sda_oe_i;
  initial scl_o = 1'b1;
  task automatic hw();
    repeat (4) @(negedge clk_i);
  endtask : hw
  // Start and repeated start both begin from a low or idle clock.
  task automatic start();
    drv = 1'b1;
    hw();
    scl_o = 1'b1;
    hw();
    drv = 1'b0;
    hw();
    scl_o = 1'b0;
    hw();
  endtask : start
  task automatic stop();
    drv = 1'b0;
    hw();
    scl_o = 1'b1;
    hw();
    drv = 1'b1;
    hw();
  endtask : stop
  // Data changes only while the clock is low, so no false start or stop.
  task automatic bit_io(input logic b, output logic r);
    drv = b;
    hw();
    scl_o = 1'b1;
    hw();
    r = sda_o;
    scl_o = 1'b0;
    hw();
  endtask : bit_io
  task automatic wbyte(input logic [7:0] b, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ok = ok & ~r;
  endtask : wbyte
  // The host acknowledges every byte but the last one.
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask : rbyte
  task automatic wtrans(input logic [6:0] a, input logic [15:0] d, inout logic ok);
    start();
    wbyte({a, 1'b0}, ok);
    wbyte(8'h08, ok);
    wbyte(d[7:0], ok);
    wbyte(d[15:8], ok);
    stop();
  endtask : wtrans
  task automatic rword(input logic [6:0] a, output logic [15:0] d, inout logic ok);
    start();
    wbyte({a, 1'b0}, ok);
    wbyte(8'h08, ok);
    start();
    wbyte({a, 1'b1}, ok);
    rbyte(1'b0, d[7:0]);
    rbyte(1'b1, d[15:8]);
    stop();
  endtask : rword
endmodule : bghs_smb_host
`default_nettype wire

// ---- tb/bghs_gpio_tb.sv ----
// Self-checking testbench of the bridge GPIO block.
`timescale 1ns/10ps
`default_nettype none
`define BGHS_CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module bghs_gpio_tb
  import bghs_pkg::*;
;
  localparam logic [6:0] ADDR = 7'h65;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hotplug_strap_i = 1'b1, mgmt_bus_strap_lo_i = 1'b1, mgmt_bus_strap_hi_i = 1'b0, fwd_mode_i = 1'b0;
  logic ext_arb_i = 1'b0, cfg_req_i = 1'b0, cfg_we_i = 1'b0, ind_msg_in_valid_i = 1'b0, ind_msg_in_attn_i = 1'b0;
  logic btn_msg_i = 1'b0, slot_ctl_wr_i = 1'b0, cmd_done_i = 1'b0, dll_active_i = 1'b0, hp_en_i = 1'b1;
  logic [1:0] ind_msg_in_state_i = 2'h0, slot_attn_ctl_i = 2'h0, slot_pwr_ctl_i = 2'h0;
  logic [2:0] req_n_i = 3'h7, arb_gnt_n_i = 3'h7;
  logic [3:0] xgpi_i = 4'h0, gpio_i = 4'h5;
  logic [4:0] slot_sts_clr_i = 5'h00;
  logic [15:0] cfg_addr_i = 16'h0000;
  logic [31:0] cfg_wdata_i = 32'h0000_0000;
  logic scl_i, sda_i, eeprom_mode_o, cfg_ack_o, gpio3_o, gpio3_oe_o, btn_msg_o;
  logic ind_msg_valid_o, hp_event_o, sda_o, sda_oe_o, ok;
  logic [1:0] ind_msg_attn_o, ind_msg_pwr_o;
  logic [2:0] gnt_n_o, gnt_oe_o;
  logic [3:0] xgpo_o, xgpo_oe_o, gpo = 4'h0, en = 4'h0;
  logic [7:0] slot_sts_o;
  logic [15:0] w;
  logic [31:0] cfg_rdata_o, rd, d;
  int num_errors = 0, n_checks = 0, cnt;
  logic [31:0] corner [5] = '{32'h0000_00F0, 32'h0000_F000, 32'hFFFF_FFFF, 32'h0000_0F0F, 32'h0000_000F};
  // Core clock of 25 ns.
  always #12.5 clk_i = ~clk_i;
  // Short counts keep debounce and blink inside a brief run.
  bghs_gpio #(.DB_CYC(24'h4), .BLINK_CYC(24'h8)) i_bghs_gpio (.clk_i, .rst_i, .hotplug_strap_i,
    .mgmt_bus_strap_lo_i, .mgmt_bus_strap_hi_i, .fwd_mode_i, .ext_arb_i, .eeprom_mode_o, .cfg_req_i, .cfg_we_i,
    .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_ack_o, .xgpi_i, .xgpo_o, .xgpo_oe_o, .req_n_i, .arb_gnt_n_i,
    .gnt_n_o, .gnt_oe_o, .gpio_i, .gpio3_o, .gpio3_oe_o, .ind_msg_in_valid_i, .ind_msg_in_attn_i,
    .ind_msg_in_state_i, .btn_msg_o, .ind_msg_valid_o, .ind_msg_attn_o, .ind_msg_pwr_o, .btn_msg_i, .slot_ctl_wr_i,
    .slot_attn_ctl_i, .slot_pwr_ctl_i, .cmd_done_i, .dll_active_i, .hp_en_i, .slot_sts_clr_i, .slot_sts_o,
    .hp_event_o, .scl_i, .sda_i, .sda_o, .sda_oe_o);
  bghs_smb_host i_bghs_smb_host (.clk_i, .sda_oe_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  function automatic logic [3:0] nx(input logic [3:0] o, input logic [3:0] c, input logic [3:0] s);
    return (o & ~c) | s;
  endfunction : nx
  function automatic logic [31:0] img();
    return {12'h000, xgpi_i, en, en, gpo, gpo};
  endfunction : img
  task automatic cfg(input logic we, input logic [15:0] a, input logic [31:0] wd);
    cfg_req_i = 1'b1;
    cfg_we_i = we;
    cfg_addr_i = a;
    cfg_wdata_i = wd;
    cyc(1);
    `BGHS_CHK("ack", 1'b1, cfg_ack_o)
    rd = cfg_rdata_o;
    cfg_req_i = 1'b0;
    cyc(1);
  endtask : cfg
  // One status bit must rise with its event, then all are cleared.
  task automatic evt(input int b, input logic hp);
    cyc(1);
    btn_msg_i = 1'b0;
    cmd_done_i = 1'b0;
    `BGHS_CHK("sts", 1'b1, slot_sts_o[b])
    `BGHS_CHK("hp_event", hp, hp_event_o)
    slot_sts_clr_i = 5'h1F;
    cyc(1);
    slot_sts_clr_i = 5'h00;
    cyc(1);
  endtask : evt
  task automatic ind(input logic a, input logic [1:0] s);
    ind_msg_in_valid_i = 1'b1;
    ind_msg_in_attn_i = a;
    ind_msg_in_state_i = s;
    cyc(1);
    ind_msg_in_valid_i = 1'b0;
    cyc(2);
  endtask : ind
  task automatic count(input int n, input logic sel);
    cnt = 0;
    repeat (n) begin
      cyc(1);
      cnt += int'((sel ? gpio3_oe_o : btn_msg_o) === 1'b1);
    end
  endtask : count
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // The run needs well under 20000 cycles.
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(41258));
    cyc(10);
    rst_i = 1'b0;
    cyc(2);
    for (int i = 0; i < 24; i++) begin
      d = (i < 5) ? corner[i] : $urandom();
      xgpi_i = 4'($urandom());
      arb_gnt_n_i = 3'($urandom());
      cfg(1'b1, 16'h0304, d);
      gpo = nx(gpo, d[3:0], d[7:4]);
      en = nx(en, d[11:8], d[15:12]);
      `BGHS_CHK("gpo", gpo, xgpo_o)
      `BGHS_CHK("gpo_en", en, xgpo_oe_o)
      `BGHS_CHK("gnt", {3'h7, arb_gnt_n_i}, {gnt_oe_o, gnt_n_o})
      cfg(1'b0, 16'h0304, 32'h0);
      `BGHS_CHK("reg", img(), rd)
    end
    // Unmapped place: reads zero, writes leave the register alone.
    cfg(1'b1, 16'h0308, 32'h0000_FFFF);
    cfg(1'b0, 16'h0308, 32'h0);
    `BGHS_CHK("unmapped", 32'h0, rd)
    ext_arb_i = 1'b1;
    req_n_i = 3'h5;
    cyc(2);
    cfg(1'b0, 16'h0304, 32'h0);
    `BGHS_CHK("arb_gpi", req_n_i, rd[18:16])
    `BGHS_CHK("arb_gpo", gpo[2:0], gnt_n_o)
    ext_arb_i = 1'b0;
    slot_sts_clr_i = 5'h1F;
    cyc(1);
    slot_sts_clr_i = 5'h00;
    cyc(1);
    dll_active_i = 1'b1;
    evt(4, 1'b1);
    gpio_i[2] = 1'b0;
    evt(1, 1'b1);
    gpio_i[0] = 1'b0;
    evt(2, 1'b1);
    cmd_done_i = 1'b1;
    evt(3, 1'b1);
    hp_en_i = 1'b0;
    btn_msg_i = 1'b1;
    evt(0, 1'b0);
    hp_en_i = 1'b1;
    `BGHS_CHK("levels", 3'h4, slot_sts_o[7:5])
    slot_attn_ctl_i = IND_BLINK;
    slot_pwr_ctl_i = IND_ON;
    slot_ctl_wr_i = 1'b1;
    cyc(1);
    slot_ctl_wr_i = 1'b0;
    `BGHS_CHK("ind_msg", {1'b1, IND_BLINK, IND_ON}, {ind_msg_valid_o, ind_msg_attn_o, ind_msg_pwr_o})
    fwd_mode_i = 1'b1;
    ind(1'b1, IND_ON);
    `BGHS_CHK("gpio3 attn", 2'h3, {gpio3_oe_o, gpio3_o})
    ind(1'b0, IND_ON);
    ind(1'b1, IND_OFF);
    `BGHS_CHK("gpio3 pwr", 2'h2, {gpio3_oe_o, gpio3_o})
    ind(1'b0, IND_OFF);
    `BGHS_CHK("gpio3 dark", 1'b0, gpio3_oe_o)
    ind(1'b1, IND_BLINK);
    count(32, 1'b1);
    `BGHS_CHK("blink", 16, cnt)
    ind(1'b1, IND_OFF);
    // A short glitch must not count as a press; a held press gives one message.
    gpio_i[1] = 1'b1;
    cyc(2);
    gpio_i[1] = 1'b0;
    count(20, 1'b0);
    `BGHS_CHK("glitch", 0, cnt)
    gpio_i[1] = 1'b1;
    count(20, 1'b0);
    `BGHS_CHK("press", 1, cnt)
    ok = 1'b1;
    i_bghs_smb_host.wtrans(7'h66, 16'h0000, ok);
    `BGHS_CHK("wrong addr", 1'b0, ok)
    ok = 1'b1;
    i_bghs_smb_host.wtrans(ADDR, 16'h0000, ok);
    i_bghs_smb_host.wtrans(ADDR, 16'h0304, ok);
    i_bghs_smb_host.wtrans(ADDR, 16'h5F0A, ok);
    gpo = nx(gpo, 4'hA, 4'h0);
    en = nx(en, 4'hF, 4'h5);
    cyc(4);
    `BGHS_CHK("smb ack", 1'b1, ok)
    cfg(1'b0, 16'h0304, 32'h0);
    `BGHS_CHK("smb write", img(), rd)
    for (int k = 0; k < 2; k++) begin
      ok = 1'b1;
      i_bghs_smb_host.wtrans(ADDR, 16'h0000, ok);
      i_bghs_smb_host.wtrans(ADDR, 16'h0304 + 16'(2 * k), ok);
      i_bghs_smb_host.rword(ADDR, w, ok);
      `BGHS_CHK("smb read", {1'b1, 16'(img() >> (16 * k))}, {ok, w})
    end
    mgmt_bus_strap_hi_i = 1'b1;
    ok = 1'b1;
    i_bghs_smb_host.wtrans(ADDR, 16'h0000, ok);
    `BGHS_CHK("bus off", 2'h0, {ok, eeprom_mode_o})
    end_of_test();
  end
endmodule : bghs_gpio_tb
`default_nettype wire
